// ### hdl/hipc_regs.sv
module hipc_regs (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // register access from the serial slave
    input wire hipc_pkg::hipc_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // pins and neighbouring logic
    input wire logic [hipc_pkg::PIN_W-1:0] prog_pin_i,
    input wire logic address_strap_pin_i,
    input wire logic watchdog_expired_i,
    input wire logic [15:0] irq_source_i,
    input wire logic override_pending_i,
    input wire logic power_switch_progress_i,
    input wire logic [1:0] output_only_level_i,
    // controls and interrupt
    output logic irq_o,
    output logic general_call_accept_o,
    output logic fast_plus_select_o,
    output logic staged_pin_apply_o,
    output logic soft_chip_reset_o,
    output logic [6:0] bus_slave_id_o,
    output logic output_only_pin_a_o,
    output logic output_only_pin_b_o
);
    import hipc_pkg::*;

    hipc_top_s st_reg;
    hipc_top_s st_next;
    logic [SYNC_W-1:0] sync_level;
    logic [PIN_W-1:0] pin_level;
    logic strap_level;
    logic [PIN_W-1:0] pin_flags;
    logic [PIN_W-1:0] flag_clear;
    logic mask_wr;
    logic ctrl_wr;
    logic apply_wr;
    logic soft_chip_reset_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and change flags
    hipc_pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .raw_i({address_strap_pin_i, prog_pin_i}),
        .level_o(sync_level)
    );

    assign pin_level = sync_level[PIN_W-1:0];
    assign strap_level = sync_level[PIN_W];

    // write one clears, per byte lane
    assign flag_clear[7:0] = (reg_req_i.wr && reg_req_i.addr == ADDR_FLAGS_LO) ?
        reg_req_i.wdata : 8'h00;
    assign flag_clear[15:8] = (reg_req_i.wr && reg_req_i.addr == ADDR_FLAGS_HI) ?
        reg_req_i.wdata : 8'h00;

    // detection only once the synchroniser has settled
    hipc_change_flags u_flags (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(pin_level),
        .arm_i(st_reg.cfg == HIPC_CFG_DONE),
        .clear_i(flag_clear),
        .flags_o(pin_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // write decode
    assign mask_wr = reg_req_i.wr &&
        (reg_req_i.addr == ADDR_MASK_LO || reg_req_i.addr == ADDR_MASK_HI);
    assign ctrl_wr = reg_req_i.wr && reg_req_i.addr == ADDR_CTRL_LO;
    assign apply_wr = ctrl_wr && reg_req_i.wdata[CTRL_APPLY_BIT];
    assign soft_chip_reset_wr = ctrl_wr && reg_req_i.wdata[CTRL_SOFT_CHIP_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;

        // start-up: wait for strap to settle, load address, report ready
        case (st_reg.cfg)
            HIPC_CFG_SETTLE: begin
                st_next.settle = st_reg.settle + 3'h1;
                if (st_reg.settle == CFG_SETTLE_CYCLES) begin
                    st_next.cfg = HIPC_CFG_LOAD;
                end
            end
            HIPC_CFG_LOAD: begin
                st_next.slave_id = strap_level ? SLAVE_ID_STRAP_HIGH :
                    SLAVE_ID_STRAP_LOW;
                st_next.cfg = HIPC_CFG_DONE;
            end
            HIPC_CFG_DONE: begin
                st_next.cfg = HIPC_CFG_DONE;
            end
            default: begin
                st_next.cfg = HIPC_CFG_SETTLE;
            end
        endcase

        // ready clears itself once the host has read the control byte
        if (reg_req_i.rd && reg_req_i.addr == ADDR_CTRL_LO) begin
            st_next.ready = 1'h0;
        end
        if (st_reg.cfg == HIPC_CFG_LOAD) begin
            st_next.ready = 1'h1;
        end

        // apply request held while an override is pending
        st_next.apply_pulse = 1'h0;
        if (st_reg.apply_req && !override_pending_i) begin
            st_next.apply_pulse = 1'h1;
            st_next.apply_req = 1'h0;
        end

        // soft reset lasts one cycle
        st_next.soft_chip_reset = 1'h0;

        // software writes
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                ADDR_MASK_LO: begin
                    st_next.irq_mask[7:0] = reg_req_i.wdata & MASK_WRITABLE[7:0];
                end
                ADDR_MASK_HI: begin
                    st_next.irq_mask[15:8] = reg_req_i.wdata & MASK_WRITABLE[15:8];
                end
                ADDR_CTRL_LO: begin
                    st_next.gen_call = reg_req_i.wdata[CTRL_GEN_CALL_BIT];
                    st_next.fast_plus = reg_req_i.wdata[CTRL_FAST_PLUS_BIT];
                    if (apply_wr) begin
                        st_next.apply_req = 1'h1;
                    end
                    if (soft_chip_reset_wr) begin
                        st_next.soft_chip_reset = 1'h1;
                    end
                end
                ADDR_SLAVE_ID: begin
                    st_next.slave_id = reg_req_i.wdata[6:0];
                end
                ADDR_PMASK_LO: begin
                    st_next.pin_mask[7:0] = reg_req_i.wdata;
                end
                ADDR_PMASK_HI: begin
                    st_next.pin_mask[15:8] = reg_req_i.wdata;
                end
                default: begin
                    st_next.busy = st_reg.busy;
                end
            endcase
        end

        // summary status and interrupt output
        st_next.summary = irq_source_i & SUM_EXT_BITS;
        st_next.summary[SUM_PIN_BIT] = |(pin_flags & st_reg.pin_mask);
        st_next.summary[SUM_WDOG_BIT] = watchdog_expired_i;
        st_next.summary[SUM_READY_BIT] = st_reg.ready;
        st_next.irq = |(st_reg.summary & st_reg.irq_mask);

        st_next.busy = power_switch_progress_i;

        // output-only pins stay low until configuration ends
        st_next.gpo = (st_reg.cfg == HIPC_CFG_DONE) ? output_only_level_i : 2'h0;

        // read answer one cycle after the request
        st_next.rvalid = reg_req_i.rd;
        st_next.rdata = 8'h00;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                ADDR_SUMMARY_LO: st_next.rdata = st_reg.summary[7:0];
                ADDR_SUMMARY_HI: st_next.rdata = st_reg.summary[15:8];
                ADDR_MASK_LO: st_next.rdata = st_reg.irq_mask[7:0];
                ADDR_MASK_HI: st_next.rdata = st_reg.irq_mask[15:8];
                ADDR_CTRL_LO: begin
                    st_next.rdata = {2'h0, st_reg.gen_call, 1'h0, st_reg.fast_plus,
                        st_reg.ready, st_reg.apply_req, st_reg.soft_chip_reset};
                end
                ADDR_SLAVE_ID: st_next.rdata = {1'h0, st_reg.slave_id};
                ADDR_SWITCH: st_next.rdata = {7'h00, st_reg.busy};
                ADDR_LEVEL_LO: st_next.rdata = pin_level[7:0];
                ADDR_LEVEL_HI: st_next.rdata = pin_level[15:8];
                ADDR_FLAGS_LO: st_next.rdata = pin_flags[7:0];
                ADDR_FLAGS_HI: st_next.rdata = pin_flags[15:8];
                ADDR_PMASK_LO: st_next.rdata = st_reg.pin_mask[7:0];
                ADDR_PMASK_HI: st_next.rdata = st_reg.pin_mask[15:8];
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= HIPC_TOP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign reg_rvalid_o = st_reg.rvalid;
    assign irq_o = st_reg.irq;
    assign general_call_accept_o = st_reg.gen_call;
    assign fast_plus_select_o = st_reg.fast_plus;
    assign staged_pin_apply_o = st_reg.apply_pulse;
    assign soft_chip_reset_o = st_reg.soft_chip_reset;
    assign bus_slave_id_o = st_reg.slave_id;
    assign output_only_pin_a_o = st_reg.gpo[0];
    assign output_only_pin_b_o = st_reg.gpo[1];

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence apply_go;
        st_reg.apply_req && !override_pending_i && !apply_wr;
    endsequence

    sequence apply_fire;
        staged_pin_apply_o && !st_reg.apply_req ##1 !staged_pin_apply_o;
    endsequence

    sequence soft_chip_reset_once;
        soft_chip_reset_wr ##1 !soft_chip_reset_wr;
    endsequence

    apply_done_a: assert property (apply_go |=> apply_fire)
        else $error("staged apply did not fire and clear");

    apply_hold_a: assert property (st_reg.apply_req && override_pending_i |=>
        !staged_pin_apply_o && st_reg.apply_req)
        else $error("apply went ahead during an override");

    soft_chip_reset_pulse_a: assert property (soft_chip_reset_once |-> soft_chip_reset_o ##1
        !soft_chip_reset_o)
        else $error("soft reset not a single cycle pulse");

    mask_reserved_a: assert property (
        (st_reg.irq_mask & ~MASK_WRITABLE) == 16'h0000)
        else $error("reserved mask bit set");

    mask_block_a: assert property (
        st_reg.irq_mask == 16'h0000 && !mask_wr |=> !irq_o)
        else $error("interrupt with all mask bits clear");

    wdog_irq_a: assert property (
        watchdog_expired_i && st_reg.irq_mask[SUM_WDOG_BIT] && !mask_wr |-> ##2 irq_o)
        else $error("unmasked watchdog did not raise the interrupt");

    pin_summary_a: assert property (|(pin_flags & st_reg.pin_mask) |=>
        st_reg.summary[SUM_PIN_BIT])
        else $error("masked pin flag missing from summary");

    ready_mirror_a: assert property (st_reg.ready |=> st_reg.summary[SUM_READY_BIT])
        else $error("summary does not mirror ready");

    strap_load_a: assert property (st_reg.cfg == HIPC_CFG_LOAD |=>
        bus_slave_id_o == ($past(strap_level) ? SLAVE_ID_STRAP_HIGH : SLAVE_ID_STRAP_LOW))
        else $error("slave address not taken from strap");

    busy_read_a: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_SWITCH |=>
        reg_rvalid_o && reg_rdata_o == {7'h00, $past(power_switch_progress_i, 2)})
        else $error("switch progress read wrong");

    gpo_low_a: assert property (st_reg.cfg != HIPC_CFG_DONE |=>
        !output_only_pin_a_o && !output_only_pin_b_o)
        else $error("output-only pin high before configuration");

    gen_call_wr_a: assert property (ctrl_wr |=>
        general_call_accept_o == $past(reg_req_i.wdata[CTRL_GEN_CALL_BIT]))
        else $error("general call bit not taken from the write");

    fast_plus_wr_a: assert property (ctrl_wr |=>
        fast_plus_select_o == $past(reg_req_i.wdata[CTRL_FAST_PLUS_BIT]))
        else $error("fast-plus bit not taken from the write");

    ready_set_a: assert property (st_reg.cfg == HIPC_CFG_LOAD |=> st_reg.ready)
        else $error("ready not raised after start-up");

    slave_id_wr_a: assert property (st_reg.cfg == HIPC_CFG_DONE && reg_req_i.wr &&
        reg_req_i.addr == ADDR_SLAVE_ID |=> bus_slave_id_o == $past(reg_req_i.wdata[6:0]))
        else $error("slave address write lost");

    busy_follow_a: assert property (1'b1 |=>
        st_reg.busy == $past(power_switch_progress_i))
        else $error("switch progress bit does not follow the switch");

    level_read_a: assert property (
        reg_req_i.rd && reg_req_i.addr == ADDR_LEVEL_LO |=>
        reg_rdata_o == $past(pin_level[7:0]))
        else $error("pin level read wrong");

    wdog_summary_a: assert property (
        watchdog_expired_i |=> st_reg.summary[SUM_WDOG_BIT])
        else $error("watchdog expiry missing from summary");

    irq_set_a: assert property (|(st_reg.summary & st_reg.irq_mask) |=> irq_o)
        else $error("enabled summary bit did not raise the interrupt");

    irq_clear_a: assert property (
        (st_reg.summary & st_reg.irq_mask) == 16'h0000 |=> !irq_o)
        else $error("interrupt high with nothing enabled pending");

endmodule // hipc_regs

// ### inc/hipc_pkg.sv
// How it works
// - Cleared mask bit blocks its summary interrupt; bits 12 and 6 reset set.
// - Control bit 5 makes the serial slave accept the general-call address.
// - Control bit 3, reset to 1, selects fast-mode-plus for the serial slave.
// - Control bit 2 reports configuration done after reset; it clears itself.
// - Setting control bit 1 applies all staged pin settings, then clears it.
// - The apply request waits while an override is pending; it clears when the apply fires.
// - Writing 1 to control bit 0 starts a chip reset; the bit self-clears.
// - The slave identity register holds the 7-bit slave address; bit 7 reserved.
// - The slave address after reset comes from the address strap pin level.
// - Switch progress bit 0 reads 1 while the power switch handles a write.
// - Pin level snapshot bit n shows the present level of programmable pin n.
// - Both output-only pins are low when the external reset is released.
// - A level change on programmable pin n sets change flag n.
// - Writing 1 clears a change flag and re-arms it; writing 0 does nothing.
// - A set change flag with its mask bit set raises the pin summary interrupt.
// - Pin change mask bit n lets changes on pin n reach the summary interrupt.
// - Summary bit 1 follows the masked change flags; cleared via the flags or the pin change mask.
// - Summary bit 12 mirrors the ready bit, bit 6 the watchdog expiry.
package hipc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // byte addresses on the serial configuration access port
    localparam logic [7:0] ADDR_SUMMARY_LO = 8'h10;
    localparam logic [7:0] ADDR_SUMMARY_HI = 8'h11;
    localparam logic [7:0] ADDR_MASK_LO = 8'h14;
    localparam logic [7:0] ADDR_MASK_HI = 8'h15;
    localparam logic [7:0] ADDR_CTRL_LO = 8'h18;
    localparam logic [7:0] ADDR_CTRL_HI = 8'h19;
    localparam logic [7:0] ADDR_SLAVE_ID = 8'h1A;
    localparam logic [7:0] ADDR_SWITCH = 8'h1B;
    localparam logic [7:0] ADDR_LEVEL_LO = 8'h20;
    localparam logic [7:0] ADDR_LEVEL_HI = 8'h21;
    localparam logic [7:0] ADDR_FLAGS_LO = 8'h22;
    localparam logic [7:0] ADDR_FLAGS_HI = 8'h23;
    localparam logic [7:0] ADDR_PMASK_LO = 8'h24;
    localparam logic [7:0] ADDR_PMASK_HI = 8'h25;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions, reset values, write masks
    localparam int CTRL_GEN_CALL_BIT = 5;
    localparam int CTRL_FAST_PLUS_BIT = 3;
    localparam int CTRL_READY_BIT = 2;
    localparam int CTRL_APPLY_BIT = 1;
    localparam int CTRL_SOFT_CHIP_RESET_BIT = 0;
    localparam int SUM_PIN_BIT = 1;
    localparam int SUM_WDOG_BIT = 6;
    localparam int SUM_READY_BIT = 12;
    localparam logic [15:0] MASK_RESET = 16'h1040;
    localparam logic [15:0] MASK_WRITABLE = 16'h57FF;
    localparam logic [15:0] SUM_EXT_BITS = 16'h47BD;
    localparam logic GEN_CALL_RESET = 1'h0;
    localparam logic FAST_PLUS_RESET = 1'h1;
    localparam logic [6:0] SLAVE_ID_STRAP_LOW = 7'h28;
    localparam logic [6:0] SLAVE_ID_STRAP_HIGH = 7'h29;
    localparam int PIN_W = 16;
    localparam int SYNC_W = 17;
    localparam logic [2:0] CFG_SETTLE_CYCLES = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        HIPC_CFG_SETTLE = 2'b00,
        HIPC_CFG_LOAD = 2'b01,
        HIPC_CFG_DONE = 2'b10
    } hipc_cfg_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hipc_req_s;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] stable;
    } hipc_sync_s;

    typedef struct packed {
        logic [PIN_W-1:0] prev;
        logic [PIN_W-1:0] flags;
    } hipc_flag_s;

    typedef struct packed {
        logic [15:0] irq_mask;
        logic [15:0] pin_mask;
        logic gen_call;
        logic fast_plus;
        logic ready;
        logic apply_req;
        logic apply_pulse;
        logic soft_chip_reset;
        logic [6:0] slave_id;
        hipc_cfg_e cfg;
        logic [2:0] settle;
        logic [15:0] summary;
        logic irq;
        logic busy;
        logic [7:0] rdata;
        logic rvalid;
        logic [1:0] gpo;
    } hipc_top_s;

    localparam hipc_top_s HIPC_TOP_RESET = '{
        irq_mask: MASK_RESET,
        pin_mask: 16'h0000,
        gen_call: GEN_CALL_RESET,
        fast_plus: FAST_PLUS_RESET,
        ready: 1'h0,
        apply_req: 1'h0,
        apply_pulse: 1'h0,
        soft_chip_reset: 1'h0,
        slave_id: 7'h00,
        cfg: HIPC_CFG_SETTLE,
        settle: 3'h0,
        summary: 16'h0000,
        irq: 1'h0,
        busy: 1'h0,
        rdata: 8'h00,
        rvalid: 1'h0,
        gpo: 2'h0
    };

endpackage

// ### hdl/hipc_pin_sync.sv
module hipc_pin_sync (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // raw pins and settled levels
    input wire logic [hipc_pkg::SYNC_W-1:0] raw_i,
    output logic [hipc_pkg::SYNC_W-1:0] level_o
);
    import hipc_pkg::*;

    hipc_sync_s st_reg;
    hipc_sync_s st_next;
    logic [SYNC_W-1:0] stable_next;

    // level counts once stages two and three agree
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
        assign stable_next[i] = (st_reg.s2[i] == st_reg.s3[i]) ? st_reg.s3[i] : st_reg.stable[i];
    end

    always_comb begin
        st_next = st_reg;
        st_next.s1 = raw_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.stable = stable_next;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.stable;

    stable_agree_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_reg.s2 == st_reg.s3 |=> level_o == $past(st_reg.s3))
        else $error("settled level does not follow agreeing stages");

endmodule // hipc_pin_sync

// ### hdl/hipc_change_flags.sv
module hipc_change_flags (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // levels, arming and software clears
    input wire logic [hipc_pkg::PIN_W-1:0] level_i,
    input wire logic arm_i,
    input wire logic [hipc_pkg::PIN_W-1:0] clear_i,
    // sticky flags
    output logic [hipc_pkg::PIN_W-1:0] flags_o
);
    import hipc_pkg::*;

    hipc_flag_s st_reg;
    hipc_flag_s st_next;
    logic [PIN_W-1:0] change;
    logic [PIN_W-1:0] flag_next;

    for (genvar i = 0; i < PIN_W; i++) begin : g_pin
        // either direction counts
        assign change[i] = arm_i && (level_i[i] != st_reg.prev[i]);
        // a new change beats a clear in the same cycle
        assign flag_next[i] = change[i] | (st_reg.flags[i] & ~clear_i[i]);
    end

    always_comb begin
        st_next = st_reg;
        st_next.prev = level_i;
        st_next.flags = flag_next;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags_o = st_reg.flags;

    change_sets_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        arm_i && level_i[0] != st_reg.prev[0] |=> flags_o[0])
        else $error("pin change did not set its flag");

    clear_wins_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        clear_i[3] && !(arm_i && level_i[3] != st_reg.prev[3]) |=> !flags_o[3])
        else $error("write one did not clear the flag");

    zero_keeps_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        flags_o[5] && !clear_i[5] |=> flags_o[5])
        else $error("flag lost without a clear");

endmodule // hipc_change_flags

// ### testbench/hipc_host_model.sv
module hipc_host_model
    import hipc_pkg::*;
(
    // clock
    input wire logic ref_clk_i,
    // register port
    output hipc_pkg::hipc_req_s req_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial req_o = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // released address and data are inverted, never left at the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i) #1;
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_i) #1;
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // answer stands for the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i) #1;
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk_i) #1;
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hEE;
    endtask

    // no new switch write until progress reads idle or 20 reads have passed
    task automatic poll_idle();
        logic [7:0] d;
        d = 8'h01;
        for (int i = 0; i < 20 && d[0] !== 1'b0; i++) begin
            rd(ADDR_SWITCH, d);
        end
    endtask
endmodule // hipc_host_model

// ### testbench/tb_host_irq_pin_control_regs.sv
module tb_host_irq_pin_control_regs;
    import hipc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    hipc_req_s req;
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] pin = 16'h0000;
    logic strap = 1'b1;
    logic wd = 1'b0;
    logic ovr = 1'b0;
    logic [15:0] src = 16'h0000;
    logic busy = 1'b0;
    logic irq, gc, fp, ap, sr, ga, gb;
    logic [6:0] sid;
    int err_count = 0;
    int samples_checked = 0;
    int ap_cnt = 0;
    int sr_cnt = 0;
    int c;

    always #4 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        ap_cnt += int'(ap === 1'b1);
        sr_cnt += int'(sr === 1'b1);
    end

    hipc_host_model host (
        .ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid)
    );

    hipc_regs uut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .prog_pin_i(pin),
        .address_strap_pin_i(strap), .watchdog_expired_i(wd), .irq_source_i(src),
        .override_pending_i(ovr), .power_switch_progress_i(busy),
        .output_only_level_i(2'h3), .irq_o(irq), .general_call_accept_o(gc),
        .fast_plus_select_o(fp), .staged_pin_apply_o(ap), .soft_chip_reset_o(sr),
        .bus_slave_id_o(sid), .output_only_pin_a_o(ga), .output_only_pin_b_o(gb)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        host.rd(a, d);
        chk(n, {8'h00, e}, {8'h00, d});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200us;
        err_count++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(20);
        rst_n_i = 1'b1;
        chk("gpo_rel", 16'h0, {14'h0, gb, ga});
        cyc(12);
        chk("irq_rdy", 16'h1, {15'h0, irq});
        rc(8'h1A, 8'h29, "sid_strap");
        rc(8'h14, 8'h40, "mask_lo");
        rc(8'h15, 8'h10, "mask_hi");
        rc(8'h18, 8'h0C, "ctl_rdy");
        rc(8'h18, 8'h08, "ctl_sc");
        cyc(3);
        chk("irq_off", 16'h0, {15'h0, irq});
        host.wr(8'h14, 8'hFF);
        host.wr(8'h15, 8'hFF);
        rc(8'h15, 8'h57, "mask_ro");
        host.wr(8'h14, 8'h00);
        host.wr(8'h15, 8'h00);
        host.wr(8'h18, 8'h28);
        cyc(2);
        chk("gcall", 16'h1, {15'h0, gc});
        rc(8'h18, 8'h28, "ctl_gc");
        host.wr(8'h18, 8'h00);
        cyc(2);
        chk("fplus", 16'h0, {15'h0, fp});
        c = sr_cnt;
        host.wr(8'h18, 8'h01);
        cyc(3);
        chk("soft_chip_reset", 16'h1, 16'(sr_cnt - c));
        rc(8'h18, 8'h00, "sr_sc");
        ovr = 1'b1;
        c = ap_cnt;
        host.wr(8'h18, 8'h02);
        cyc(5);
        chk("ap_held", 16'h0, 16'(ap_cnt - c));
        rc(8'h18, 8'h02, "ap_pend");
        ovr = 1'b0;
        cyc(4);
        chk("ap_go", 16'h1, 16'(ap_cnt - c));
        rc(8'h18, 8'h00, "ap_sc");
        host.wr(8'h1A, 8'hFF);
        rc(8'h1A, 8'h7F, "sid_wr");
        chk("sid_o", 16'h7F, {9'h0, sid});
        busy = 1'b1;
        cyc(2);
        rc(8'h1B, 8'h01, "busy1");
        busy = 1'b0;
        host.poll_idle();
        host.wr(8'h1B, 8'hFF);
        rc(8'h1B, 8'h00, "busy0");
        rc(8'h30, 8'h00, "unmapped");
        host.wr(8'h24, 8'hFF);
        host.wr(8'h25, 8'hFF);
        rc(8'h25, 8'hFF, "pmask");
        host.wr(8'h14, 8'h02);
        pin = 16'hA5C3;
        cyc(10);
        rc(8'h20, 8'hC3, "lvl_lo");
        rc(8'h21, 8'hA5, "lvl_hi");
        rc(8'h22, 8'hC3, "flg_lo");
        rc(8'h23, 8'hA5, "flg_hi");
        chk("irq_pin", 16'h1, {15'h0, irq});
        rc(8'h10, 8'h02, "sum_pin");
        host.wr(8'h22, 8'h00);
        rc(8'h22, 8'hC3, "w0_keep");
        host.wr(8'h24, 8'h00);
        host.wr(8'h25, 8'h00);
        cyc(3);
        chk("irq_pmsk", 16'h0, {15'h0, irq});
        host.wr(8'h24, 8'hFF);
        host.wr(8'h25, 8'hFF);
        host.wr(8'h22, 8'hC3);
        host.wr(8'h23, 8'hA5);
        cyc(3);
        rc(8'h22, 8'h00, "w1c_lo");
        rc(8'h23, 8'h00, "w1c_hi");
        chk("irq_clr", 16'h0, {15'h0, irq});
        pin = 16'h0000;
        cyc(10);
        rc(8'h22, 8'hC3, "fall_lo");
        rc(8'h23, 8'hA5, "fall_hi");
        host.wr(8'h14, 8'h40);
        wd = 1'b1;
        cyc(4);
        chk("irq_wd", 16'h1, {15'h0, irq});
        rc(8'h10, 8'h42, "sum_wd");
        host.wr(8'h14, 8'h00);
        cyc(3);
        chk("irq_msk", 16'h0, {15'h0, irq});
        wd = 1'b0;
        src = 16'hFFFF;
        cyc(3);
        chk("irq_src_off", 16'h0, {15'h0, irq});
        host.wr(8'h14, 8'h01);
        cyc(3);
        chk("irq_src", 16'h1, {15'h0, irq});
        rc(8'h11, 8'h47, "sum_src_hi");
        rc(8'h10, 8'hBF, "sum_src_lo");
        src = 16'h0000;
        strap = 1'b0;
        rst_n_i = 1'b0;
        cyc(3);
        rst_n_i = 1'b1;
        chk("gpo_rel2", 16'h0, {14'h0, gb, ga});
        chk("fp_rst", 16'h1, {15'h0, fp});
        cyc(12);
        rc(8'h1A, 8'h28, "sid_low");
        chk("sid_low_o", 16'h28, {9'h0, sid});
        chk("irq_rdy2", 16'h1, {15'h0, irq});
        complete_run();
    end
endmodule // tb_host_irq_pin_control_regs
